/* File: include/asp_defs.svh */
/*
 * Constants of the serial port and mode control block: config word
 * layout and reset value, frame lengths, result limits and timing.
 * Assumes a 250 MHz system clock; included by the design files.
 */
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ---------------------------------------------------------------
// config word
// ---------------------------------------------------------------
`define ASP_CFG_RESET 16'h058b
`define ASP_CFG_SS 15
`define ASP_CFG_MODE 8
`define ASP_CFG_PULLUP 3

// ---------------------------------------------------------------
// result and frame
// ---------------------------------------------------------------
`define ASP_RES_W 16
`define ASP_RES_MAX 16'h7fff
`define ASP_RES_MIN 16'h8000
`define ASP_RES_ZERO 16'h0000
`define ASP_FRAME_BITS 6'd48
`define ASP_CFG_BITS 6'd16

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ASP_CLK_MHZ 250
`define ASP_TMO_US 30800
`define ASP_TMO_CYC (`ASP_TMO_US * `ASP_CLK_MHZ)
`define ASP_EARLY_US 8
`define ASP_EARLY_CYC (`ASP_EARLY_US * `ASP_CLK_MHZ)
`define ASP_TMO_RST_CYC 3'd4

`endif

/* File: include/asp_pkg.sv */
/*
 * Types of the serial port and mode control block.
 * Assumes nothing of its surroundings.
 */
package asp_pkg;

   // conversion sequencer states
   typedef enum logic [1:0] {S_OFF, S_CONV, S_CONT} asp_state_t;

endpackage : asp_pkg

/* File: rtl/asp_link.sv */
/*
 * Link side of the serial port: runs on the host's serial clock.
 * Assumes link_rst is high while chip select is high or on timeout,
 * and that result_word is quiet around the first rising edge.
 */
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_link (
   input wire logic serial_clk, // host serial clock
   input wire logic link_rst, // serial interface reset, async
   input wire logic sys_rst, // device reset, async
   input wire logic serial_in, // host data in
   input wire logic [15:0] result_word, // buffered result to send
   input wire logic ready_n_level, // ready level outside a frame
   output logic pin_out, // level for the out/ready pin
   output logic [15:0] cfg_word, // last config word captured
   output logic cfg_tgl, // toggles per captured config word
   output logic frame_tgl, // toggles per frame start
   output logic busy // frame in progress
);

   logic [5:0] pbits_q, pbits_d;
   logic [47:0] sh_q, sh_d;
   logic busy_q, busy_d;
   logic ftgl_q, ftgl_d;
   logic [5:0] nbits_q, nbits_d;
   logic [15:0] in_q, in_d;
   logic [15:0] cfg_q, cfg_d;
   logic ctgl_q, ctgl_d;
   logic start;

   // ---------------------------------------------------------------
   // rising edge: output shifter
   // ---------------------------------------------------------------
   // a frame starts on the first rise, or after 48 bits when the
   // host keeps chip select low
   // 48-bit frame wrap
   always_comb begin
      start = (pbits_q == 6'd0) || (pbits_q == `ASP_FRAME_BITS);
      ftgl_d = ftgl_q;
      if (start) begin
         pbits_d = 6'd1;
         sh_d = {result_word, 32'h0};
         ftgl_d = ~ftgl_q;
      end else if (pbits_q == `ASP_CFG_BITS) begin
         pbits_d = pbits_q + 6'd1;
         sh_d = {1'b0, cfg_q[14:0], 32'h0};
      end else begin
         pbits_d = pbits_q + 6'd1;
         sh_d = {sh_q[46:0], 1'b0};
      end
      busy_d = (pbits_d != `ASP_FRAME_BITS);
   end

   always_ff @(posedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         pbits_q <= 6'd0;
         sh_q <= 48'h0;
         busy_q <= 1'b0;
      end else begin
         pbits_q <= pbits_d;
         sh_q <= sh_d;
         busy_q <= busy_d;
      end
   end

   // frame toggle survives chip select so no false edge is seen
   always_ff @(posedge serial_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ftgl_q <= 1'b0;
      end else begin
         ftgl_q <= ftgl_d;
      end
   end

   // ---------------------------------------------------------------
   // falling edge: input capture
   // ---------------------------------------------------------------
   // sample din on fall
   always_comb begin
      nbits_d = (nbits_q == `ASP_FRAME_BITS) ? 6'd1 : nbits_q + 6'd1;
      in_d = in_q;
      cfg_d = cfg_q;
      ctgl_d = ctgl_q;
      if (nbits_d <= `ASP_CFG_BITS) begin
         in_d = {in_q[14:0], serial_in};
      end
      if (nbits_d == `ASP_CFG_BITS) begin
         cfg_d = {in_q[14:0], serial_in};
         ctgl_d = ~ctgl_q;
      end
   end

   always_ff @(negedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         nbits_q <= 6'd0;
         in_q <= 16'h0;
      end else begin
         nbits_q <= nbits_d;
         in_q <= in_d;
      end
   end

   // captured word stays put for the system side to pick up
   always_ff @(negedge serial_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_q <= `ASP_CFG_RESET;
         ctgl_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         ctgl_q <= ctgl_d;
      end
   end

   // data while the frame runs, ready level before and after it
   assign pin_out = ((pbits_q != 6'd0) &&
                     !((pbits_q == `ASP_FRAME_BITS) &&
                       (nbits_q == `ASP_FRAME_BITS))) ? sh_q[47]
                                                      : ready_n_level;
   assign cfg_word = cfg_q;
   assign cfg_tgl = ctgl_q;
   assign frame_tgl = ftgl_q;
   assign busy = busy_q;

endmodule : asp_link

/* File: rtl/asp_serial_ctrl.sv */
/*
 * Serial host port and conversion-mode control of a sigma-delta ADC.
 * Assumes a conversion core on the system clock that runs while
 * conv_run is high and pulses conv_done with a result; the host
 * drives chip select, serial clock and data in.
 */
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_serial_ctrl #(
   parameter int unsigned RAW_W = `ASP_RES_W,
   parameter int unsigned PER_W = 24,
   parameter int unsigned TMO_CYC = `ASP_TMO_CYC
) (
   input wire logic clock, // system clock, 250 MHz
   input wire logic sys_rst, // device reset, active high
   input wire logic serial_clk, // host serial clock
   input wire logic chip_sel_n, // host chip select, active low
   input wire logic serial_in, // host data in
   output logic serial_out_ready_n, // out/ready pin level
   output logic serial_out_oe, // out/ready pin drive enable
   output logic serial_out_pullup, // weak pull-up on out/ready pin
   output logic [15:0] cfg_word, // live config word to the core
   output logic conv_run, // core converting
   input wire logic conv_done, // core result strobe
   input wire logic [RAW_W-1:0] conv_raw // core result, signed
);

   localparam logic [PER_W-1:0] EARLY = PER_W'(`ASP_EARLY_CYC);
   localparam logic [31:0] TMO_LAST = 32'(TMO_CYC - 1);
   localparam logic [4:0] SYNC_RST = 5'b00001;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [4:0] sync_in, s1_q, s2_q;
   logic cs_s, sclk_s, ctgl_s, ftgl_s, busy_s;
   logic link_rst, link_pin;
   logic [15:0] link_cfg;
   logic link_ctgl, link_ftgl, link_busy;

   // ---------------------------------------------------------------
   // synchronisers for pins and link-domain levels
   // ---------------------------------------------------------------
   assign sync_in = {link_busy, link_ftgl, link_ctgl, serial_clk,
                     chip_sel_n};
   genvar g;
   for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            s1_q[g] <= SYNC_RST[g];
            s2_q[g] <= SYNC_RST[g];
         end else begin
            s1_q[g] <= sync_in[g];
            s2_q[g] <= s1_q[g];
         end
      end
   end

   assign cs_s = s2_q[0];
   assign sclk_s = s2_q[1];
   assign ctgl_s = s2_q[2];
   assign ftgl_s = s2_q[3];
   assign busy_s = s2_q[4];

   // ---------------------------------------------------------------
   // conversion sequencer and config
   // ---------------------------------------------------------------
   asp_pkg::asp_state_t state_q, state_d;
   logic [15:0] cfg_q, cfg_d, conv_q, conv_d, xfer_q, xfer_d, clip;
   logic ctgl_p_q, ftgl_p_q, run_q, run_d, seen_q, seen_d;
   logic wr, took, frame_start;
   logic signed [31:0] raw_ext;
   assign wr = ctgl_s ^ ctgl_p_q;
   assign frame_start = ftgl_s ^ ftgl_p_q;
   assign took = conv_done && (state_q != asp_pkg::S_OFF);
   // saturate core word to 16 bits
   always_comb begin
      raw_ext = 32'(signed'(conv_raw));
      if (raw_ext > 32'sd32767) begin
         clip = `ASP_RES_MAX;
      end else if (raw_ext < -32'sd32768) begin
         clip = `ASP_RES_MIN;
      end else begin
         clip = raw_ext[15:0];
      end
   end

   always_comb begin
      state_d = state_q;
      cfg_d = cfg_q;
      conv_d = conv_q;
      seen_d = seen_q;
      // react to the done strobe only outside power-down
      if (took) begin
         conv_d = clip;
         seen_d = 1'b1;
      end
      if (wr) begin
         cfg_d = {1'b0, link_cfg[14:0]};
      end
      unique case (state_q)
         asp_pkg::S_OFF: begin
            if (wr && !link_cfg[`ASP_CFG_MODE]) begin
               state_d = asp_pkg::S_CONT;
            end else if (wr && link_cfg[`ASP_CFG_SS]) begin
               state_d = asp_pkg::S_CONV;
            end
         end
         asp_pkg::S_CONV: begin
            if (wr && !link_cfg[`ASP_CFG_MODE]) begin
               state_d = asp_pkg::S_CONT;
            end else if (conv_done) begin
               state_d = asp_pkg::S_OFF;
            end
         end
         asp_pkg::S_CONT: begin // select not consulted
            // only a mode write of 1 leaves
            if (wr && link_cfg[`ASP_CFG_MODE]) begin
               state_d = asp_pkg::S_OFF;
            end
         end
         default: state_d = asp_pkg::S_OFF;
      endcase
      run_d = (state_d != asp_pkg::S_OFF);
      xfer_d = busy_s ? xfer_q : conv_q;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= asp_pkg::S_OFF;
         cfg_q <= `ASP_CFG_RESET;
         conv_q <= `ASP_RES_ZERO; // zero until first result
         xfer_q <= `ASP_RES_ZERO;
         seen_q <= 1'b0;
         run_q <= 1'b0;
         ctgl_p_q <= 1'b0;
         ftgl_p_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         conv_q <= conv_d;
         xfer_q <= xfer_d;
         seen_q <= seen_d;
         run_q <= run_d;
         ctgl_p_q <= ctgl_s;
         ftgl_p_q <= ftgl_s;
      end
   end

   // ---------------------------------------------------------------
   // data-ready level
   // ---------------------------------------------------------------
   // the period of the last conversion predicts the next done strobe;
   // the first period is unknown, so no early rise before it
   logic new_q, new_d, rdy_n_q, rdy_n_d, early;
   logic [PER_W-1:0] cnt_q, cnt_d, per_q, per_d;
   always_comb begin
      // new result pending, set beats clear
      new_d = took ? 1'b1 : (frame_start ? 1'b0 : new_q);
      cnt_d = took ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 1'b1);
      per_d = took ? cnt_q : per_q;
      early = (state_q == asp_pkg::S_CONT) && new_q &&
              ({1'b0, cnt_q} + {1'b0, EARLY} >= {1'b0, per_q});
      // low if new result and no early rise, else high
      rdy_n_d = !new_q || early;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         new_q <= 1'b0;
         cnt_q <= '0;
         per_q <= '1;
         rdy_n_q <= 1'b1;
      end else begin
         new_q <= new_d;
         cnt_q <= cnt_d;
         per_q <= per_d;
         rdy_n_q <= rdy_n_d;
      end
   end

   // ---------------------------------------------------------------
   // pin drive, pull-up and serial clock timeout
   // ---------------------------------------------------------------
   logic oe_q, oe_d, pu_q, pu_d, tmo_on_q, tmo_on_d;
   logic [31:0] tmo_q, tmo_d;
   logic [2:0] tmo_left_q, tmo_left_d;
   always_comb begin
      oe_d = !cs_s;
      pu_d = cs_s && cfg_q[`ASP_CFG_PULLUP];
      tmo_d = sclk_s ? 32'h0 : ((tmo_q > TMO_LAST) ? tmo_q
                                                  : tmo_q + 32'h1);
      tmo_left_d = (tmo_q == TMO_LAST && !sclk_s) ? `ASP_TMO_RST_CYC
                 : ((tmo_left_q != 3'd0) ? tmo_left_q - 3'd1 : 3'd0);
      tmo_on_d = (tmo_left_d != 3'd0);
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         oe_q <= 1'b0;
         pu_q <= 1'b1;
         tmo_q <= 32'h0;
         tmo_left_q <= 3'd0;
         tmo_on_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
         pu_q <= pu_d;
         tmo_q <= tmo_d;
         tmo_left_q <= tmo_left_d;
         tmo_on_q <= tmo_on_d;
      end
   end

   // clock is held low by then, so releasing this reset is safe
   assign link_rst = sys_rst || chip_sel_n || tmo_on_q;
   asp_link u_link (
      .serial_clk(serial_clk),
      .link_rst(link_rst),
      .sys_rst(sys_rst),
      .serial_in(serial_in),
      .result_word(xfer_q),
      .ready_n_level(rdy_n_q),
      .pin_out(link_pin),
      .cfg_word(link_cfg),
      .cfg_tgl(link_ctgl),
      .frame_tgl(link_ftgl),
      .busy(link_busy)
   );
   // pin level is the one mux the data-ready overlay needs
   assign serial_out_ready_n = link_pin;
   assign serial_out_oe = oe_q;
   assign serial_out_pullup = pu_q;
   assign cfg_word = cfg_q;
   assign conv_run = run_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_off_idle;
      (state_q == asp_pkg::S_OFF) && !wr |=> !conv_run;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("core runs in power-down");
   property p_ss_start;
      wr && (state_q == asp_pkg::S_OFF) && link_cfg[`ASP_CFG_MODE] &&
      link_cfg[`ASP_CFG_SS] |=> (state_q == asp_pkg::S_CONV) && conv_run
      ##0 !cfg_q[`ASP_CFG_SS];
   endproperty
   a_ss_start: assert property (p_ss_start)
      else $error("start bit did not start a conversion");
   property p_ss_ignore;
      wr && (state_q == asp_pkg::S_CONV) && link_cfg[`ASP_CFG_MODE] &&
      !conv_done |=> (state_q == asp_pkg::S_CONV);
   endproperty
   a_ss_ignore: assert property (p_ss_ignore)
      else $error("start bit disturbed a conversion");
   property p_cont_store;
      (state_q == asp_pkg::S_CONT) && conv_done && !wr |=>
      (conv_q == $past(clip)) && (state_q == asp_pkg::S_CONT) && conv_run;
   endproperty
   a_cont_store: assert property (p_cont_store)
      else $error("continuous result not stored");
   property p_mode_cont;
      wr && !link_cfg[`ASP_CFG_MODE] |=> (state_q == asp_pkg::S_CONT);
   endproperty
   a_mode_cont: assert property (p_mode_cont)
      else $error("mode write 0 did not enter continuous");
   property p_desel_release;
      cs_s |=> !serial_out_oe ##0
      (serial_out_pullup == cfg_q[`ASP_CFG_PULLUP]);
   endproperty
   a_desel_release: assert property (p_desel_release)
      else $error("pin driven or pull-up wrong while deselected");
   property p_sel_ready;
      $fell(cs_s) && new_q && !early |=> serial_out_oe && !rdy_n_q;
   endproperty
   a_sel_ready: assert property (p_sel_ready)
      else $error("no ready low on select with new result");
   property p_done_low;
      took && (cnt_q > EARLY) && !frame_start ##1 !frame_start
      |=> !rdy_n_q;
   endproperty
   a_done_low: assert property (p_done_low)
      else $error("ready not low after conversion");
   property p_timeout;
      !sclk_s && (tmo_q == TMO_LAST) |=> tmo_on_q [*4] ##1 !tmo_on_q;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("serial timeout reset wrong length");
   property p_zero_first;
      !seen_q |-> (conv_q == `ASP_RES_ZERO) && !cfg_q[`ASP_CFG_SS];
   endproperty
   a_zero_first: assert property (p_zero_first)
      else $error("result not zero before first conversion");
   property p_hold_frame;
      busy_s |=> $stable(xfer_q);
   endproperty
   a_hold_frame: assert property (p_hold_frame)
      else $error("send buffer changed during a frame");
   c_single: cover property ((state_q == asp_pkg::S_CONV) ##[1:1000]
      (state_q == asp_pkg::S_OFF));
   c_cont: cover property ((state_q == asp_pkg::S_CONT) && took);
   c_early: cover property (early);
   c_tmo: cover property (tmo_on_q);

endmodule : asp_serial_ctrl

/* File: verif/asp_host_model.sv */
/*
 * Host model: serial bus master for the out/ready port.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps

module asp_host_model (
   output logic serial_clk, // link clock, still outside frames
   output logic chip_sel_n, // chip select, active low
   output logic serial_in, // data to the device
   input wire logic pin // resolved out/ready wire
);
   // ------------------------------------------------
   // idle levels
   // ------------------------------------------------
   // clock idles low
   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      serial_in = 1'b1;
   end

   task automatic sel(input logic lvl);
      chip_sel_n = lvl;
      #23.7;
   endtask : sel

   // caller picks the bit count (16, 48, or 5 in the timeout test); din changes on rise, msb first
   task automatic shift(input logic [15:0] din, input int n,
         output logic [47:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         // past bit 16 din is ignored, so keep it toggling
         serial_in = (i < 16) ? din[15-i] : ~serial_in;
         serial_clk = 1'b1;
         #6;
         dout = {dout[46:0], pin};
         serial_clk = 1'b0;
         #6;
      end
   endtask : shift
endmodule : asp_host_model

/* File: verif/tb_asp_serial_ctrl.sv */
/*
 * Bench of the serial port and mode control block: host model on
 * the link, core strobes driven here. Assumes the in-design checks.
 */
`timescale 1ns/1ps

module tb_asp_serial_ctrl;
   localparam int unsigned RAW_W = 18;
   logic clock, sys_rst, conv_done, oe, pu, ready_n, run;
   logic sclk, cs_n, din;
   logic [RAW_W-1:0] conv_raw;
   logic [15:0] cfg;
   logic [47:0] dout;
   wire pin;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;

   // ------------------------------------------------
   // clock, pin, timeout
   // ------------------------------------------------
   // 250 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // a released pin floats unless pulled up
   assign pin = oe ? ready_n : (pu ? 1'b1 : 1'bz);
   // hang guard, well above the expected run of about 10000 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         end_of_test();
      end
   end

   asp_serial_ctrl #(.RAW_W(RAW_W), .TMO_CYC(200)) u_asp_serial_ctrl (
      .clock(clock), .sys_rst(sys_rst), .serial_clk(sclk),
      .chip_sel_n(cs_n), .serial_in(din), .serial_out_ready_n(ready_n),
      .serial_out_oe(oe), .serial_out_pullup(pu), .cfg_word(cfg),
      .conv_run(run), .conv_done(conv_done), .conv_raw(conv_raw));
   asp_host_model u_asp_host_model (
      .serial_clk(sclk), .chip_sel_n(cs_n), .serial_in(din), .pin(pin));

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic chk_w(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_w

   task automatic chk_b(input string nm, input logic e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_b

   // one core strobe, then let the result settle
   task automatic done(input logic [RAW_W-1:0] r);
      @(posedge clock);
      conv_done <= 1'b1;
      conv_raw <= r;
      @(posedge clock);
      conv_done <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : done

   // whole frame; st is the pin level just after select
   task automatic xfer(input logic [15:0] w, input int n,
         output logic st);
      u_asp_host_model.sel(1'b0);
      st = pin;
      u_asp_host_model.shift(w, n, dout);
      u_asp_host_model.sel(1'b1);
      repeat (6) @(posedge clock);
   endtask : xfer

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset;
      logic st;
      chk_w("cfg", 16'h058b, cfg);
      chk_b("run", 1'b0, run);
      chk_b("oe", 1'b0, oe);
      chk_b("pullup", 1'b1, pu);
      xfer(16'h058b, 16, st);
      chk_b("no new", 1'b1, st);
      chk_w("first", 16'h0000, dout[15:0]);
      $display("test reset done");
   endtask : t_reset

   task automatic t_single;
      logic st;
      xfer(16'h858b, 48, st);
      chk_w("readback", 16'h058b, dout[31:16]);
      chk_w("tail", 16'h0000, dout[15:0]);
      chk_b("start", 1'b1, run);
      chk_w("ss clear", 16'h058b, cfg);
      // second start while converting must not restart
      xfer(16'h858b, 16, st);
      done(18'h1ffff);
      chk_b("one shot", 1'b0, run);
      // host waits 8 us after ready
      repeat (2000) @(posedge clock);
      xfer(16'h058b, 16, st);
      chk_b("new", 1'b0, st);
      chk_w("clip hi", 16'h7fff, dout[15:0]);
      xfer(16'h058b, 16, st);
      chk_b("old", 1'b1, st);
      chk_w("again", 16'h7fff, dout[15:0]);
      $display("test single done");
   endtask : t_single

   task automatic t_cont;
      logic st;
      xfer(16'h048b, 16, st);
      chk_b("cont", 1'b1, run);
      done(18'h20000);
      done(18'h3ffff);
      chk_b("deselected", 1'b1, run);
      xfer(16'h048b, 16, st);
      chk_w("latest", 16'hffff, dout[15:0]);
      // a result landing mid-frame waits for the next frame
      fork
         xfer(16'h048b, 16, st);
         begin
            #100;
            done(18'h20000);
         end
      join
      chk_w("locked", 16'hffff, dout[15:0]);
      xfer(16'h048b, 16, st);
      chk_w("clip lo", 16'h8000, dout[15:0]);
      u_asp_host_model.sel(1'b0);
      chk_b("idle high", 1'b1, pin);
      // a period longer than the 8 us lead, else ready never shows low
      repeat (2100) @(posedge clock);
      done(18'h00005);
      chk_b("ready", 1'b0, pin);
      repeat (3000) @(posedge clock);
      done(18'h00abc);
      repeat (500) @(posedge clock);
      chk_b("still low", 1'b0, ready_n);
      repeat (700) @(posedge clock);
      chk_b("early rise", 1'b1, ready_n);
      xfer(16'h058b, 16, st);
      chk_b("leave", 1'b0, run);
      $display("test continuous done");
   endtask : t_cont

   task automatic t_pullup;
      logic st;
      xfer(16'h0583, 16, st);
      chk_b("pullup off", 1'b0, pu);
      chk_b("released", 1'b0, oe);
      xfer(16'h058b, 16, st);
      chk_b("pullup on", 1'b1, pu);
      $display("test pullup done");
   endtask : t_pullup

   task automatic t_timeout;
      u_asp_host_model.sel(1'b0);
      u_asp_host_model.shift(16'h058b, 5, dout);
      repeat (260) @(posedge clock);
      u_asp_host_model.shift(16'h058b, 16, dout);
      u_asp_host_model.sel(1'b1);
      chk_w("restart", 16'h0abc, dout[15:0]);
      $display("test timeout done");
   endtask : t_timeout

   task automatic end_of_test;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // main sequence: 16-cycle reset, then the scenarios
   initial begin
      sys_rst = 1'b1;
      conv_done = 1'b0;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_reset();
      t_single();
      t_cont();
      t_pullup();
      t_timeout();
      end_of_test();
   end
endmodule : tb_asp_serial_ctrl
